// ===== hdl/rxfs_consts.svh
// Constants of the receive buffer status and stream output block
// Assumes inclusion by the package and by the block's single module
`ifndef RXFS_CONSTS_SVH
`define RXFS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Read state codes
// ----------------------------------------------------------------------------
`define RXFS_RD_IDLE     2'h0
`define RXFS_RD_BUF0     2'h1
`define RXFS_RD_BUF1     2'h2
`define RXFS_RD_DONE     2'h3

// ----------------------------------------------------------------------------
// Queue state codes
// ----------------------------------------------------------------------------
`define RXFS_Q_IDLE      2'h0
`define RXFS_Q_POP       2'h1
`define RXFS_Q_WAIT      2'h2
`define RXFS_Q_DELAY     2'h3

// ----------------------------------------------------------------------------
// Field positions of a stream word
// ----------------------------------------------------------------------------
`define RXFS_DT_LSB      0
`define RXFS_VC_LSB      6
`define RXFS_WC_LSB      8
`define RXFS_PAY_LSB     24

// ----------------------------------------------------------------------------
// Defaults
// ----------------------------------------------------------------------------
`define RXFS_DEF_DEPTH   16
`define RXFS_DEF_QDEPTH  4
`define RXFS_DEF_PAYW    32

`endif

// ===== hdl/rxfs_pkg.sv
// Types of the receive buffer status and stream output block
// Assumes the constants header is on the include path
`include "rxfs_consts.svh"

package rxfs_pkg;

  // --------------------------------------------------------------------------
  // Buffer organisation
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RXFS_ORG_SINGLE,
    RXFS_ORG_QUEUE,
    RXFS_ORG_ALTERNATING_TWO_BUFFER_MODE
  } rxfs_org_t;

  // --------------------------------------------------------------------------
  // Input word: payload plus packet header fields
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  vc;
    logic [5:0]  dt;
    logic [15:0] wc;
    logic [31:0] payload;
  } rxfs_word_t;

  // --------------------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rd_state;
    logic [1:0] q_state;
    logic       buffer_empty_flag;
    logic       buffer_zero_full_flag;
    logic       buffer_one_full_flag;
    logic       queue_empty;
    logic       queue_full;
  } rxfs_status_t;

endpackage : rxfs_pkg

// ===== hdl/rxfs_stream_out.sv
// Receive buffer read side: buffers, queue, status and output stream
// Assumes writer and reader share clk; the writer honours in_ready
//
// Behaviour
// - Single mode: read state 00 idle, 01 reading buffer zero
// - Queue mode: read state 00 idle, 01 reading zero, 11 done
// - Alternating mode: 00 idle, 01 zero, 10 one, 11 done
// - Empty flag for the buffer and full flag for buffer zero
// - Full flag for buffer one, meaningful only in alternating mode
// - Non-single modes report queue state 00,01 pop,10 wait,11 delay
// - Queue pops one entry, waits for readout done, delays one cycle, then idles
// - Stream valid high whenever output word is valid for transfer
// - Stream word carries raw bytes or payload with vc, dt, wc
`timescale 1ns/1ns
`include "rxfs_consts.svh"

module rxfs_stream_out #(
  parameter int DEPTH  = `RXFS_DEF_DEPTH,
  parameter int QDEPTH = `RXFS_DEF_QDEPTH
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // Configuration
  input  wire rxfs_pkg::rxfs_org_t   org,
  input  wire logic                  packet_mode,
  // Write side: one packet per frame, closed by in_last or by the DEPTH-th word
  input  wire logic                  in_valid,
  input  wire rxfs_pkg::rxfs_word_t  in_word,
  input  wire logic                  in_last,
  output logic                       in_ready,
  // Status
  output rxfs_pkg::rxfs_status_t     status,
  // Output stream
  input  wire logic                  axis_tready,
  output logic                       axis_tvalid,
  output logic [55:0]                axis_tdata
);

  localparam int AW = $clog2(DEPTH);
  localparam int QW = $clog2(QDEPTH);

  typedef enum logic [1:0] {RD_IDLE, RD_BUF0, RD_BUF1, RD_DONE} rxfs_rd_t;
  typedef enum logic [1:0] {Q_IDLE, Q_POP, Q_WAIT, Q_DELAY} rxfs_q_t;

  typedef struct packed {
    rxfs_rd_t           rd;
    rxfs_q_t            q;
    logic               rdy;       // Registered write-side ready
    logic               rsel;      // Buffer to read next, alternating mode
    logic [1:0][AW:0]   cnt;       // Words held per buffer
    logic [1:0][AW:0]   len;       // Words per closed frame
    logic [1:0]         closed;
    logic               wsel;
    logic [AW-1:0]      rptr;
    logic [QW:0]        qcnt;
    logic [1:0]         ocnt;      // Two-entry output buffer
    logic [1:0][55:0]   obuf;
    rxfs_pkg::rxfs_status_t st;
    logic               tvalid;
    logic [55:0]        tdata;
  } rxfs_st_t;

  rxfs_st_t s;
  rxfs_st_t next_s;
  logic [55:0] mem [2][DEPTH];
  logic [AW:0] wcnt;
  logic        wr_en;
  logic [55:0] rd_word;

  function automatic logic [55:0] pack_word(input rxfs_pkg::rxfs_word_t w, input logic pm);
    pack_word = pm ? {w.payload, w.wc, w.vc, w.dt} : {24'h00_0000, w.payload};
  endfunction : pack_word

  function automatic logic [1:0] rd_code(input rxfs_rd_t r);
    unique case (r)
      RD_IDLE: rd_code = `RXFS_RD_IDLE;
      RD_BUF0: rd_code = `RXFS_RD_BUF0;
      RD_BUF1: rd_code = `RXFS_RD_BUF1;
      RD_DONE: rd_code = `RXFS_RD_DONE;
    endcase
  endfunction : rd_code

  function automatic logic [1:0] q_code(input rxfs_q_t q);
    unique case (q)
      Q_IDLE:  q_code = `RXFS_Q_IDLE;
      Q_POP:   q_code = `RXFS_Q_POP;
      Q_WAIT:  q_code = `RXFS_Q_WAIT;
      Q_DELAY: q_code = `RXFS_Q_DELAY;
    endcase
  endfunction : q_code

  // --------------------------------------------------------------------------
  // Buffer write port
  // --------------------------------------------------------------------------
  assign wcnt  = s.cnt[s.wsel];
  assign wr_en = in_valid && in_ready;
  assign rd_word = mem[s.rd == RD_BUF1][s.rptr];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[s.wsel][wcnt[AW-1:0]] <= pack_word(in_word, packet_mode);
    end
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic       rd_fire;
    logic       pop;
    logic       bsel;
    logic       odrain;
    logic       ofill;
    logic       q_single;
    rd_fire  = 1'b0;
    pop      = 1'b0;
    bsel     = 1'b0;
    ofill    = 1'b0;
    q_single = (org == rxfs_pkg::RXFS_ORG_SINGLE);
    odrain   = s.tvalid && axis_tready;
    next_s   = s;
    // Write side
    if (wr_en) begin
      next_s.cnt[s.wsel] = s.cnt[s.wsel] + 1'b1;
      if (in_last || wcnt == (AW+1)'(DEPTH - 1)) begin
        next_s.closed[s.wsel] = 1'b1;
        next_s.len[s.wsel]    = s.cnt[s.wsel] + 1'b1;
        if (org == rxfs_pkg::RXFS_ORG_ALTERNATING_TWO_BUFFER_MODE) begin
          next_s.wsel = ~s.wsel;
        end
        if (!q_single) begin
          next_s.qcnt = s.qcnt + 1'b1;
        end
      end
    end
    // ------------------------------------------------------------------------
    // Queue controller
    // ------------------------------------------------------------------------
    pop = 1'b0;
    unique case (s.q)
      Q_IDLE:  if (!q_single && s.qcnt != '0 && s.rd == RD_IDLE) next_s.q = Q_POP;
      Q_POP: begin
        pop = 1'b1;
        next_s.q = Q_WAIT;
      end
      Q_WAIT:  if (s.rd == RD_DONE) next_s.q = Q_DELAY;
      Q_DELAY: next_s.q = Q_IDLE;
    endcase
    if (pop) begin
      next_s.qcnt = next_s.qcnt - 1'b1;
    end
    // ------------------------------------------------------------------------
    // Read side
    // ------------------------------------------------------------------------
    bsel    = (s.rd == RD_BUF1);
    ofill   = 1'b0;
    rd_fire = (s.ocnt != 2'h2) || odrain;
    unique case (s.rd)
      RD_IDLE: begin
        next_s.rptr = '0;
        if (q_single ? s.closed[0] : pop) begin
          // Frames are read in the order they were closed
          next_s.rd = s.rsel ? RD_BUF1 : RD_BUF0;
        end
      end
      RD_BUF0, RD_BUF1: begin
        if (rd_fire) begin
          ofill = 1'b1;
          next_s.rptr = s.rptr + 1'b1;
          if ((AW+1)'(s.rptr) + 1'b1 == s.len[bsel]) begin
            next_s.cnt[bsel]    = '0;
            next_s.closed[bsel] = 1'b0;
            next_s.rsel = (org == rxfs_pkg::RXFS_ORG_ALTERNATING_TWO_BUFFER_MODE) && !bsel;
            next_s.rd = q_single ? RD_IDLE : RD_DONE;
          end
        end
      end
      RD_DONE: next_s.rd = RD_IDLE;
    endcase
    // ------------------------------------------------------------------------
    // Output buffer, two entries
    // ------------------------------------------------------------------------
    if (odrain) begin
      next_s.obuf[0] = s.obuf[1];
    end
    next_s.ocnt = s.ocnt + {1'b0, ofill} - {1'b0, odrain};
    if (ofill) begin
      next_s.obuf[next_s.ocnt - 1'b1] = rd_word;
    end
    next_s.tvalid = next_s.ocnt != 2'h0;
    next_s.tdata  = next_s.obuf[0];
    // ------------------------------------------------------------------------
    // Status
    // ------------------------------------------------------------------------
    next_s.st.rd_state              = rd_code(next_s.rd);
    next_s.st.q_state               = q_single ? `RXFS_Q_IDLE : q_code(next_s.q);
    next_s.st.buffer_empty_flag     = next_s.cnt[0] == '0 && next_s.cnt[1] == '0;
    next_s.st.buffer_zero_full_flag = next_s.cnt[0] == (AW+1)'(DEPTH);
    next_s.st.buffer_one_full_flag  = (org == rxfs_pkg::RXFS_ORG_ALTERNATING_TWO_BUFFER_MODE)
                                      && next_s.cnt[1] == (AW+1)'(DEPTH);
    next_s.st.queue_empty           = !q_single && next_s.qcnt == '0;
    next_s.st.queue_full            = !q_single && next_s.qcnt == (QW+1)'(QDEPTH);
    // Writer stalls while the target buffer still holds a closed frame or the queue is full
    next_s.rdy = !next_s.closed[next_s.wsel] && next_s.qcnt != (QW+1)'(QDEPTH);
  end

  assign in_ready = s.rdy;

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.st.buffer_empty_flag <= 1'b1;
      s.rdy                  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign status      = s.st;
  assign axis_tvalid = s.tvalid;
  assign axis_tdata  = s.tdata;

endmodule : rxfs_stream_out

// ===== testbench/rxfs_sink.sv
// Downstream consumer model of the output stream
// Assumes the bench clears the captured words
`timescale 1ns/1ns
module rxfs_sink (
  // Clock, reset, pace: 0 prompt, 1 slow, 2 stall
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [1:0]  pace,
  // Stream
  input  wire logic        axis_tvalid,
  input  wire logic [55:0] axis_tdata,
  output logic             axis_tready
);
  logic [1:0]  tick = 2'h0;
  logic [55:0] got[$];
  initial axis_tready = 1'b0;
  always @(posedge clk)
    if (axis_tvalid && axis_tready) got.push_back(axis_tdata);
  always @(negedge clk) begin
    tick <= tick + 2'h1;
    axis_tready <= nrst && (pace == 2'h0 || (pace == 2'h1 && tick == 2'h0));
  end
endmodule : rxfs_sink

// ===== testbench/rxfs_stream_out_monitor.sv
// Checker of the stream output block
// Assumes one clock domain, bound to the block's ports
`timescale 1ns/1ns
module rxfs_stream_out_monitor #(
  parameter int DEPTH  = 16,
  parameter int QDEPTH = 4
) (
  // Watched ports
  input wire logic                  clk,
  input wire logic                  nrst,
  input wire rxfs_pkg::rxfs_org_t   org,
  input wire logic                  packet_mode,
  input wire logic                  in_valid,
  input wire rxfs_pkg::rxfs_word_t  in_word,
  input wire logic                  in_last,
  input wire logic                  in_ready,
  input wire rxfs_pkg::rxfs_status_t status,
  input wire logic                  axis_tready,
  input wire logic                  axis_tvalid,
  input wire logic [55:0]           axis_tdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  hold_on_stall_a: assert property (axis_tvalid && !axis_tready |=> axis_tvalid && $stable(axis_tdata))
    else $error("stream word changed while stalled");
  single_read_a: assert property (org == rxfs_pkg::RXFS_ORG_SINGLE |-> !status.rd_state[1])
    else $error("bad read state in single mode");
  queue_read_a: assert property (org == rxfs_pkg::RXFS_ORG_QUEUE |-> status.rd_state != 2'h2)
    else $error("bad read state in queue mode");
  empty_not_full_a: assert property (status.buffer_empty_flag |-> !status.buffer_zero_full_flag)
    else $error("buffer empty and full together");
  one_full_mode_a: assert property (org != rxfs_pkg::RXFS_ORG_ALTERNATING_TWO_BUFFER_MODE
    |-> !status.buffer_one_full_flag)
    else $error("buffer one full outside alternating mode");
  delay_to_idle_a: assert property (status.q_state == 2'h3 |=> status.q_state == 2'h0)
    else $error("queue delay state not one cycle");
  pop_then_wait_a: assert property (status.q_state == 2'h1 |=> status.q_state == 2'h2)
    else $error("queue pop not followed by wait");
  single_queue_a: assert property (org == rxfs_pkg::RXFS_ORG_SINGLE |-> status.q_state == 2'h0
    && !status.queue_full)
    else $error("queue status active in single mode");
  full_refuses_a: assert property (status.queue_full |-> !in_ready && !status.queue_empty)
    else $error("queue full yet writes taken");
  raw_layout_a: assert property (!packet_mode && axis_tvalid |-> axis_tdata[55:32] == 24'h00_0000)
    else $error("raw word upper bits not zero");
  cover property (axis_tvalid && !axis_tready);
  cover property (status.q_state == 2'h3);
  cover property (status.rd_state == 2'h2);
endmodule : rxfs_stream_out_monitor

bind rxfs_stream_out rxfs_stream_out_monitor #(.DEPTH(DEPTH), .QDEPTH(QDEPTH)) rxfs_stream_out_monitor_i (
  .clk(clk), .nrst(nrst), .org(org), .packet_mode(packet_mode), .in_valid(in_valid), .in_word(in_word),
  .in_last(in_last), .in_ready(in_ready), .status(status), .axis_tready(axis_tready),
  .axis_tvalid(axis_tvalid), .axis_tdata(axis_tdata));

// ===== testbench/rxfs_stream_out_test.sv
// Self-checking bench of the stream output block
// Assumes the consumer model and checker are compiled first
`timescale 1ns/1ns
module rxfs_stream_out_test;
  localparam int DEPTH = 4;
  logic                   clk = 1'b0;
  logic                   nrst = 1'b0;
  logic                   packet_mode = 1'b1;
  logic                   in_valid = 1'b0;
  logic                   in_last = 1'b0;
  logic                   in_ready, tready, tvalid;
  logic [1:0]             pace = 2'h0;
  logic [2:0]             seen_f;
  logic [3:0]             seen_rd, seen_q;
  logic [55:0]            tdata;
  logic [55:0]            exp_q[$];
  rxfs_pkg::rxfs_org_t    org = rxfs_pkg::RXFS_ORG_SINGLE;
  rxfs_pkg::rxfs_word_t   in_word = '0;
  rxfs_pkg::rxfs_status_t status;
  int                     failures = 0, tests_run = 0, cyc = 0;

  rxfs_stream_out #(.DEPTH(DEPTH), .QDEPTH(1)) rxfs_stream_out_i (.clk(clk), .nrst(nrst), .org(org),
    .packet_mode(packet_mode), .in_valid(in_valid), .in_word(in_word), .in_last(in_last),
    .in_ready(in_ready), .status(status), .axis_tready(tready), .axis_tvalid(tvalid), .axis_tdata(tdata));
  rxfs_sink rxfs_sink_i (.clk(clk), .nrst(nrst), .pace(pace), .axis_tvalid(tvalid), .axis_tdata(tdata),
    .axis_tready(tready));

  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    seen_rd[status.rd_state] <= 1'b1;
    seen_q[status.q_state] <= 1'b1;
    seen_f <= seen_f | {status.queue_full, status.buffer_one_full_flag, status.buffer_zero_full_flag};
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [55:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic setup(input rxfs_pkg::rxfs_org_t o, input logic pm, input logic [1:0] p);
    org = o;
    packet_mode = pm;
    pace = p;
    @(negedge clk);
    seen_rd = '0;
    seen_q = '0;
    seen_f = '0;
  endtask : setup

  task automatic send_frame(input int n, input logic [7:0] base);
    rxfs_pkg::rxfs_word_t w;
    for (int i = 0; i < n; i++) begin
      w = '{vc: base[1:0], dt: base[5:0] ^ 6'h15, wc: {base, 8'(i)}, payload: {base, 8'(i), 16'h5a3c}};
      in_word = w;
      in_valid = 1'b1;
      in_last = (i == n - 1);
      exp_q.push_back(packet_mode ? {w.payload, w.wc, w.vc, w.dt} : {24'h00_0000, w.payload});
      while (!in_ready) @(negedge clk);
      @(negedge clk);
    end
    in_valid = 1'b0;
    in_last = 1'b0;
    @(negedge clk);
  endtask : send_frame

  task automatic drain(input string what);
    for (int k = 0; k < 400 && rxfs_sink_i.got.size() < exp_q.size(); k++) @(negedge clk);
    repeat (6) @(negedge clk);
    chk({what, " count"}, 56'(exp_q.size()), 56'(rxfs_sink_i.got.size()));
    foreach (exp_q[j]) chk(what, exp_q[j], rxfs_sink_i.got[j]);
    chk({what, " empty"}, 56'h1, 56'(status.buffer_empty_flag));
    chk({what, " idle"}, 56'h0, 56'(status.rd_state));
    chk({what, " queue empty"}, 56'(org != rxfs_pkg::RXFS_ORG_SINGLE), 56'(status.queue_empty));
    exp_q.delete();
    rxfs_sink_i.got.delete();
  endtask : drain

  task automatic t_single;
    setup(rxfs_pkg::RXFS_ORG_SINGLE, 1'b1, 2'h1);
    send_frame(3, 8'h11);
    drain("single");
    chk("single read states", 56'h3, 56'(seen_rd));
    chk("single queue states", 56'h1, 56'(seen_q));
  endtask : t_single

  task automatic t_raw;
    setup(rxfs_pkg::RXFS_ORG_SINGLE, 1'b0, 2'h0);
    send_frame(2, 8'h22);
    send_frame(1, 8'h33);
    drain("raw");
  endtask : t_raw

  task automatic t_queue;
    setup(rxfs_pkg::RXFS_ORG_QUEUE, 1'b1, 2'h1);
    send_frame(2, 8'h44);
    send_frame(3, 8'h55);
    drain("queue");
    chk("queue read states", 56'hb, 56'(seen_rd));
    chk("queue states", 56'hf, 56'(seen_q));
  endtask : t_queue

  task automatic t_alt;
    setup(rxfs_pkg::RXFS_ORG_ALTERNATING_TWO_BUFFER_MODE, 1'b1, 2'h2);
    send_frame(DEPTH, 8'h66);
    send_frame(DEPTH, 8'h77);
    repeat (4) @(negedge clk);
    chk("alt refused", 56'h0, 56'(in_ready));
    chk("alt full flags", 56'h3, 56'(seen_f[1:0]));
    chk("alt queue full", 56'h1, 56'(seen_f[2]));
    pace = 2'h1;
    drain("alt");
    chk("alt read states", 56'hf, 56'(seen_rd));
  endtask : t_alt

  task automatic complete_run;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  initial begin
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    t_single();
    t_raw();
    t_queue();
    t_alt();
    complete_run();
  end
endmodule : rxfs_stream_out_test
